// file: logic/acs_conv_ctrl.v
`include "acs_conv_regs.vh"

module acs_conv_ctrl #(
    parameter [18:0] CAL_FULL_CYC  = `ACS_CAL_FULL_PERIODS * `ACS_MCLK_CYC_PER_PERIOD,
    parameter [18:0] CAL_DACFS_CYC = `ACS_CAL_DACFS_PERIODS * `ACS_MCLK_CYC_PER_PERIOD,
    parameter [18:0] CAL_OFS_CYC   = `ACS_CAL_OFS_PERIODS * `ACS_MCLK_CYC_PER_PERIOD
) (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire [3:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    input  wire        conversion_start_n_in,
    input  wire [13:0] sample_data_in,
    input  wire        polarity_in,
    input  wire        sclk_in,
    output wire        sclk_out,
    output wire        sclk_oe_out,
    input  wire        sync_n_in,
    output wire        dout_out,
    output reg         dout_oe_out,
    input  wire        din_in,
    output wire        din_out,
    output reg         din_oe_out,
    output reg         busy_out,
    output reg         result_ready_out,
    output reg         partial_pd_out,
    output reg         full_pd_out
);
    localparam [18:0] CONV_CYC = `ACS_CONV_PERIODS * `ACS_MCLK_CYC_PER_PERIOD;
    localparam [1:0]  ST_IDLE  = 2'h0;
    localparam [1:0]  ST_CONV  = 2'h1;
    localparam [1:0]  ST_CAL   = 2'h2;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire cst_n_s;
    wire pol_s;
    wire sclk_s;
    wire sync_n_s;
    wire din_s;

    acs_sync2 u_sync_cst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(conversion_start_n_in),
                          .rst_val_in(1'b1), .q_out(cst_n_s));
    acs_sync2 u_sync_pol (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(polarity_in),
                          .rst_val_in(1'b1), .q_out(pol_s));
    acs_sync2 u_sync_sck (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(sclk_in),
                          .rst_val_in(1'b0), .q_out(sclk_s));
    acs_sync2 u_sync_fs  (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(sync_n_in),
                          .rst_val_in(1'b1), .q_out(sync_n_s));
    acs_sync2 u_sync_din (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(din_in),
                          .rst_val_in(1'b0), .q_out(din_s));

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    reg  [15:0] ctrl_reg;
    reg  [13:0] result_reg;
    reg  [15:0] rx_word_reg;
    wire [2:0]  if_mode    = ctrl_reg[`ACS_CTRL_MODE_HI:`ACS_CTRL_MODE_LO];
    wire        din_shared = ctrl_reg[`ACS_CTRL_SHARED_BIT];
    wire        internal_clk = (if_mode == `ACS_MODE_INT_LO) || (if_mode == `ACS_MODE_INT_HI);
    wire        ctrl_wr    = reg_wr_in && (reg_addr_in == `ACS_ADDR_CTRL);
    wire        sw_conv    = ctrl_wr && reg_wdata_in[`ACS_CTRL_CONV_BIT];
    wire        sw_cal     = ctrl_wr && reg_wdata_in[`ACS_CTRL_CAL_BIT];
    wire        pm_hi      = ctrl_reg[`ACS_CTRL_PM_HI_BIT];
    wire        pm_lo      = ctrl_reg[`ACS_CTRL_PM_LO_BIT];

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= `ACS_CTRL_RESET;
        end else if (ctrl_wr) begin
            // start bits are strobes and never stored
            ctrl_reg <= {6'h00, reg_wdata_in[9:2], 2'b00};
        end
    end

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            partial_pd_out <= 1'b0;
            full_pd_out    <= 1'b0;
        end else begin
            partial_pd_out <= pm_hi && pm_lo;
            full_pd_out    <= pm_hi && !pm_lo;
        end
    end

    // ------------------------------------------------------------
    // conversion and calibration sequencer
    // ------------------------------------------------------------
    reg        cst_prev_reg;
    reg [1:0]  state_reg;
    reg [18:0] timer_reg;
    wire       pin_conv = cst_prev_reg && !cst_n_s;
    wire       powered  = !pm_hi;
    wire       done     = (state_reg != ST_IDLE) && (timer_reg == 19'h0_0000);
    wire       res_rd   = reg_rd_in && (reg_addr_in == `ACS_ADDR_RESULT);

    function [18:0] cal_len;
        input [1:0] sel;
        begin
            case (sel)
                `ACS_CAL_FULL:   cal_len = CAL_FULL_CYC - 19'h0_0001;
                `ACS_CAL_DAC_FS: cal_len = CAL_DACFS_CYC - 19'h0_0001;
                `ACS_CAL_OFFSET: cal_len = CAL_OFS_CYC - 19'h0_0001;
                default:         cal_len = CAL_FULL_CYC - 19'h0_0001;
            endcase
        end
    endfunction

    // starts while busy or powered down are dropped; the timer runs on mclk_in cycles
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cst_prev_reg     <= 1'b1;
            state_reg        <= ST_IDLE;
            timer_reg        <= 19'h0_0000;
            busy_out         <= 1'b0;
            result_reg       <= `ACS_RESULT_RESET;
            result_ready_out <= 1'b0;
        end else begin
            cst_prev_reg <= cst_n_s;
            if (res_rd) begin
                result_ready_out <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (powered && sw_cal) begin
                        state_reg <= ST_CAL;
                        timer_reg <= cal_len(reg_wdata_in[`ACS_CTRL_CALSEL_HI:`ACS_CTRL_CALSEL_LO]);
                        busy_out  <= 1'b1;
                    end else if (powered && (sw_conv || pin_conv)) begin
                        state_reg <= ST_CONV;
                        timer_reg <= CONV_CYC - 19'h0_0001;
                        busy_out  <= 1'b1;
                    end
                end
                ST_CONV, ST_CAL: begin
                    if (done) begin
                        state_reg <= ST_IDLE;
                        busy_out  <= 1'b0;
                        if (state_reg == ST_CONV) begin
                            result_reg       <= sample_data_in;
                            result_ready_out <= 1'b1;
                        end
                    end else begin
                        timer_reg <= timer_reg - 19'h0_0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_out  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // serial clock source
    // ------------------------------------------------------------
    // a master period spans two mclk_in cycles, so the generated clock is
    // high one cycle and low one cycle
    reg mper_reg;

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            mper_reg <= 1'b0;
        end else begin
            mper_reg <= !mper_reg;
        end
    end

    assign sclk_out    = mper_reg;
    assign sclk_oe_out = internal_clk;

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    reg         sck_prev_reg;
    reg         fs_prev_reg;
    reg  [15:0] tx_reg;
    reg  [15:0] rx_reg;
    reg  [4:0]  bit_cnt_reg;
    wire        sck_now    = internal_clk ? mper_reg : sclk_s;
    wire        sck_up     = !sck_prev_reg && sck_now;
    wire        sck_dn     = sck_prev_reg && !sck_now;
    wire        named_rise = pol_s ? sck_up : sck_dn;
    wire        named_fall = pol_s ? sck_dn : sck_up;
    wire        frame      = !sync_n_s;
    wire        frame_go   = fs_prev_reg && !sync_n_s;
    wire        frame_end  = !fs_prev_reg && sync_n_s;

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sck_prev_reg <= 1'b0;
            fs_prev_reg  <= 1'b1;
            tx_reg       <= 16'h0000;
            rx_reg       <= 16'h0000;
            rx_word_reg  <= 16'h0000;
            bit_cnt_reg  <= 5'h00;
            dout_oe_out  <= 1'b0;
            din_oe_out   <= 1'b0;
        end else begin
            sck_prev_reg <= sck_now;
            fs_prev_reg  <= sync_n_s;
            dout_oe_out  <= frame && !din_shared;
            if (frame_go) begin
                tx_reg      <= {2'b00, result_reg};
                bit_cnt_reg <= 5'h00;
            end else if (frame_end) begin
                rx_word_reg <= rx_reg;
                din_oe_out  <= 1'b0;
            end else if (frame) begin
                if (named_fall && (bit_cnt_reg != 5'h00)) begin
                    tx_reg <= {tx_reg[14:0], 1'b0};
                end
                if (named_rise && (bit_cnt_reg != `ACS_FRAME_BITS)) begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    rx_reg      <= {rx_reg[14:0], din_s};
                    if (din_shared && (bit_cnt_reg == 5'h00)) begin
                        din_oe_out <= 1'b1;
                    end
                    if (bit_cnt_reg == `ACS_FRAME_BITS - 5'h01) begin
                        din_oe_out <= 1'b0;
                    end
                end
            end
        end
    end

    assign dout_out = tx_reg[15];
    assign din_out  = tx_reg[15];

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ACS_ADDR_CTRL:   reg_rdata_out <= ctrl_reg;
                `ACS_ADDR_STATUS: reg_rdata_out <= {12'h000, full_pd_out, partial_pd_out,
                                                    result_ready_out, busy_out};
                `ACS_ADDR_RESULT: reg_rdata_out <= {2'b00, result_reg};
                `ACS_ADDR_RXDATA: reg_rdata_out <= rx_word_reg;
                default:          reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end
endmodule

// file: logic/acs_conv_regs.vh
`ifndef ACS_CONV_REGS_VH
`define ACS_CONV_REGS_VH
// Overview of operation
// - a conversion ends twenty master periods after its start, then the result is ready
// - full self-calibration keeps the block occupied for 250026 master periods
// - internal DAC plus system full-scale calibration takes 222228 master periods
// - system offset calibration takes 27798 master periods
// - edge select high uses serial edges as named, low uses the opposite edges
// - in interface modes four and five the block drives serial clock at master rate
// - a generated serial clock is high half and low half of one master period
// - shared data pin turns output after a rising edge, input after a later one
// - data output floats while frame sync is high, drives after it falls when the data pin is not shared
// - power bits: both high partial power-down, high and low full power-down

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ACS_ADDR_CTRL        4'h0
`define ACS_ADDR_STATUS      4'h4
`define ACS_ADDR_RESULT      4'h8
`define ACS_ADDR_RXDATA      4'hc

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define ACS_CTRL_CONV_BIT    0
`define ACS_CTRL_CAL_BIT     1
`define ACS_CTRL_CALSEL_LO   2
`define ACS_CTRL_CALSEL_HI   3
`define ACS_CTRL_PM_LO_BIT   4
`define ACS_CTRL_PM_HI_BIT   5
`define ACS_CTRL_MODE_LO     6
`define ACS_CTRL_MODE_HI     8
`define ACS_CTRL_SHARED_BIT  9
`define ACS_CTRL_RESET       16'h0000

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define ACS_STAT_BUSY_BIT    0
`define ACS_STAT_READY_BIT   1
`define ACS_STAT_PPD_BIT     2
`define ACS_STAT_FPD_BIT     3

// ------------------------------------------------------------
// calibration selections and interface modes
// ------------------------------------------------------------
`define ACS_CAL_FULL         2'h0
`define ACS_CAL_DAC_FS       2'h1
`define ACS_CAL_OFFSET       2'h2
`define ACS_MODE_INT_LO      3'h4
`define ACS_MODE_INT_HI      3'h5

// ------------------------------------------------------------
// timing, in master clock periods
// ------------------------------------------------------------
// sized to the timer width so the cycle products need no truncation
`define ACS_MCLK_CYC_PER_PERIOD 19'h0_0002
`define ACS_CONV_PERIODS     19'h0_0014
`define ACS_CAL_FULL_PERIODS 19'h3_d0aa
`define ACS_CAL_DACFS_PERIODS 19'h3_6414
`define ACS_CAL_OFS_PERIODS  19'h0_6c96
`define ACS_FRAME_BITS       5'h10
`define ACS_RESULT_RESET     14'h0000
`endif

// file: logic/acs_sync2.v
module acs_sync2 (
    input  wire mclk_in,
    input  wire rst_n_in,
    input  wire d_in,
    input  wire rst_val_in,
    output wire q_out
);
    reg meta_reg;
    reg sync_reg;

    // the reset value is a constant at every instance, tied at the port
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            meta_reg <= rst_val_in;
            sync_reg <= rst_val_in;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule

// file: dv/acs_conv_chk.sv
`include "acs_conv_regs.vh"
module acs_conv_chk #(
    parameter [18:0] CAL_FULL_CYC  = 19'h0_0064,
    parameter [18:0] CAL_DACFS_CYC = 19'h0_0050,
    parameter [18:0] CAL_OFS_CYC   = 19'h0_0020
) (
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        conversion_start_n_in,
    input wire logic [13:0] sample_data_in,
    input wire logic        polarity_in,
    input wire logic        sclk_in,
    input wire logic        sclk_out,
    input wire logic        sclk_oe_out,
    input wire logic        sync_n_in,
    input wire logic        dout_out,
    input wire logic        dout_oe_out,
    input wire logic        din_in,
    input wire logic        din_out,
    input wire logic        din_oe_out,
    input wire logic        busy_out,
    input wire logic        result_ready_out,
    input wire logic        partial_pd_out,
    input wire logic        full_pd_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    localparam logic [18:0] CONV = `ACS_CONV_PERIODS * `ACS_MCLK_CYC_PER_PERIOD;
    // --------------------------------------------
    // shadow of the control fields and busy length
    // --------------------------------------------
    logic [18:0] cnt_reg;
    logic [2:0]  mode_reg;
    logic [1:0]  pm_reg;
    logic [1:0]  kind_reg;
    logic        shr_reg;
    wire         ctl_wr = reg_wr_in && reg_addr_in == `ACS_ADDR_CTRL;
    // a start in the same write as power-down is left out: its outcome is not fixed
    wire         go = ctl_wr && |reg_wdata_in[1:0] && !reg_wdata_in[5] && !busy_out && !partial_pd_out && !full_pd_out;
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cnt_reg  <= 19'h0_0000;
            mode_reg <= 3'h0;
            pm_reg   <= 2'h0;
            shr_reg  <= 1'b0;
            kind_reg <= 2'h0;
        end else begin
            cnt_reg <= busy_out ? cnt_reg + 19'h0_0001 : 19'h0_0000;
            if (ctl_wr) begin
                mode_reg <= reg_wdata_in[8:6];
                pm_reg   <= reg_wdata_in[5:4];
                shr_reg  <= reg_wdata_in[9];
            end
            if (go) begin
                kind_reg <= !reg_wdata_in[1] ? 2'h0 : (reg_wdata_in[3:2] == 2'h3) ? 2'h1 : reg_wdata_in[3:2] + 2'h1;
            end else if (!busy_out) begin
                kind_reg <= 2'h0;
            end
        end
    end
    sequence s_go;
        go;
    endsequence
    sequence s_end;
        $fell(busy_out);
    endsequence
    property p_busy_rise;
        s_go |=> busy_out [*3];
    endproperty
    property p_conv_len;
        s_end ##0 kind_reg == 2'h0 |-> cnt_reg == CONV && result_ready_out;
    endproperty
    property p_cal_full;
        s_end ##0 kind_reg == 2'h1 |-> cnt_reg == CAL_FULL_CYC;
    endproperty
    property p_cal_dac;
        s_end ##0 kind_reg == 2'h2 |-> cnt_reg == CAL_DACFS_CYC;
    endproperty
    property p_cal_ofs;
        s_end ##0 kind_reg == 2'h3 |-> cnt_reg == CAL_OFS_CYC;
    endproperty
    property p_oe_mode;
        sclk_oe_out == (mode_reg == 3'h4 || mode_reg == 3'h5);
    endproperty
    property p_sclk_run;
        sclk_oe_out && $past(sclk_oe_out) |-> sclk_out != $past(sclk_out);
    endproperty
    property p_pd;
        ctl_wr ##1 !ctl_wr |=> partial_pd_out == (pm_reg == 2'h3) && full_pd_out == (pm_reg == 2'h2);
    endproperty
    property p_float;
        sync_n_in [*6] |-> !dout_oe_out;
    endproperty
    property p_drive;
        (!shr_reg && !sync_n_in) [*6] |-> dout_oe_out;
    endproperty
    property p_din_oe;
        din_oe_out |-> shr_reg && !dout_oe_out;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not follow start");
    a_conv_len: assert property (p_conv_len) else $error("conversion length or ready wrong");
    a_cal_full: assert property (p_cal_full) else $error("full calibration length wrong");
    a_cal_dac: assert property (p_cal_dac) else $error("dac calibration length wrong");
    a_cal_ofs: assert property (p_cal_ofs) else $error("offset calibration length wrong");
    a_oe_mode: assert property (p_oe_mode) else $error("serial clock direction wrong");
    a_sclk_run: assert property (p_sclk_run) else $error("generated clock did not toggle");
    a_pd: assert property (p_pd) else $error("power state wrong");
    a_float: assert property (p_float) else $error("data output driven outside frame");
    a_drive: assert property (p_drive) else $error("data output not driven in frame");
    a_din_oe: assert property (p_din_oe) else $error("shared pin driven wrongly");
endmodule

// file: dv/acs_host_model.sv
module acs_host_model (
    input  wire logic pol_in,
    input  wire logic dout_in,
    input  wire logic dout_oe_in,
    input  wire logic din_oe_in,
    output logic      sclk_out,
    output logic      sync_n_out,
    output logic      din_drv_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic saw_dout;
    logic saw_din;
    initial begin
        sclk_out = 1'b0;
        sync_n_out = 1'b1;
        din_drv_out = 1'b0;
    end
    // ------------------------------------------------------------
    // one frame, msb first, clock stands still between frames
    // ------------------------------------------------------------
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        saw_dout = 1'b0;
        saw_din = 1'b0;
        // every pin change lands 1 ns after a master edge, never on it
        #1 sclk_out = ~pol_in;
        #20 sync_n_out = 1'b0;
        #40;
        for (int i = 15; i >= 0; i--) begin
            din_drv_out = tx[i];
            #16 sclk_out = pol_in;
            rx[i] = dout_in;
            saw_dout |= dout_oe_in;
            saw_din |= din_oe_in;
            #16 sclk_out = ~pol_in;
        end
        #40 sync_n_out = 1'b1;
        // released line shows the inverse so a stale value never matches
        din_drv_out = ~din_drv_out;
        #60;
    endtask
endmodule

// file: dv/tb_acs_conv_ctrl.sv
`include "acs_conv_regs.vh"
module tb_acs_conv_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [18:0] CF = 19'h0_0078;
    localparam logic [18:0] CD = 19'h0_005a;
    localparam logic [18:0] CO = 19'h0_001e;
    localparam int CONV = `ACS_CONV_PERIODS * `ACS_MCLK_CYC_PER_PERIOD;
    logic        mclk_in = 1'b0;
    logic        rst_n_in, reg_wr_in, reg_rd_in, conversion_start_n_in, polarity_in;
    logic [3:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [13:0] sample_data_in;
    logic        sclk_out, sclk_oe_out, dout_out, dout_oe_out, din_out, din_oe_out;
    logic        busy_out, result_ready_out, partial_pd_out, full_pd_out;
    logic        h_sclk, h_sync_n, h_din;
    wire         sclk_w = sclk_oe_out ? sclk_out : h_sclk;
    wire         din_w = din_oe_out ? din_out : h_din;
    int          miscompares = 0;
    int          checked = 0;
    always #2 mclk_in = ~mclk_in;
    acs_conv_ctrl #(.CAL_FULL_CYC(CF), .CAL_DACFS_CYC(CD), .CAL_OFS_CYC(CO)) i_acs_conv_ctrl (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .conversion_start_n_in(conversion_start_n_in), .sample_data_in(sample_data_in), .polarity_in(polarity_in),
        .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .sync_n_in(h_sync_n),
        .dout_out(dout_out), .dout_oe_out(dout_oe_out), .din_in(din_w), .din_out(din_out),
        .din_oe_out(din_oe_out), .busy_out(busy_out), .result_ready_out(result_ready_out),
        .partial_pd_out(partial_pd_out), .full_pd_out(full_pd_out));
    // the host reads whichever data pin is driven; a floating line reads as the inverse
    acs_host_model i_acs_host_model (.pol_in(polarity_in),
        .dout_in(dout_oe_out ? dout_out : din_oe_out ? din_out : ~dout_out), .dout_oe_in(dout_oe_out),
        .din_oe_in(din_oe_out), .sclk_out(h_sclk), .sync_n_out(h_sync_n), .din_drv_out(h_din));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    // counts busy cycles; the wait for busy to rise is bounded
    task automatic meas(output int n);
        int k = 0;
        n = 0;
        #1;
        while (busy_out !== 1'b1 && k < 20) begin
            @(posedge mclk_in);
            #1 k++;
        end
        while (busy_out === 1'b1 && n < 5000) begin
            n++;
            @(posedge mclk_in);
            #1;
        end
    endtask
    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        logic [15:0] d, rx, tx;
        logic [15:0] pm [2];
        int n;
        // the second write asks for a start while powered down, which is refused
        pm = '{16'h0030, 16'h0021};
        {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        conversion_start_n_in = 1'b1;
        polarity_in = 1'b1;
        sample_data_in = 14'h2a5c;
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(`ACS_ADDR_STATUS, d); chk(d, 16'h0000);
        rd(4'h2, d); chk(d, 16'h0000);
        // second start lands while busy and must not stretch the conversion
        wr(`ACS_ADDR_CTRL, 16'h0001);
        wr(`ACS_ADDR_CTRL, 16'h0001);
        meas(n); chk(16'(n), 16'(CONV - 2));
        rd(`ACS_ADDR_STATUS, d); chk(d, 16'h0002);
        rd(`ACS_ADDR_RESULT, d); chk(d, 16'h2a5c);
        rd(`ACS_ADDR_STATUS, d); chk(d, 16'h0000);
        @(posedge mclk_in);
        sample_data_in <= 14'h1337;
        conversion_start_n_in <= 1'b0;
        meas(n); chk(16'(n), 16'(CONV));
        @(posedge mclk_in);
        conversion_start_n_in <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(`ACS_ADDR_CTRL, 16'h0002 | 16'(s << 2));
            meas(n); chk(16'(n), s == 1 ? 16'(CD) : s == 2 ? 16'(CO) : 16'(CF));
        end
        foreach (pm[i]) begin
            wr(`ACS_ADDR_CTRL, pm[i]);
            repeat (3) @(posedge mclk_in);
            rd(`ACS_ADDR_STATUS, d); chk(d & 16'h000d, pm[i][4] ? 16'h0004 : 16'h0008);
        end
        for (int m = 0; m < 6; m++) begin
            wr(`ACS_ADDR_CTRL, 16'(m << 6));
            #1 d = 16'(sclk_out);
            chk(16'(sclk_oe_out), 16'(m >= 4));
            @(posedge mclk_in);
            #1 if (m >= 4) chk(16'(sclk_out), ~d & 16'h0001);
        end
        wr(`ACS_ADDR_CTRL, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk_in);
            polarity_in <= ~polarity_in;
            repeat (4) @(posedge mclk_in);
            tx = p ? 16'h5a3c : 16'hc3a5;
            i_acs_host_model.frame(tx, rx); chk(rx, 16'h1337);
            chk(16'(i_acs_host_model.saw_dout), 16'h0001);
            chk(16'(dout_oe_out), 16'h0000);
            rd(`ACS_ADDR_RXDATA, d); chk(d, tx);
        end
        wr(`ACS_ADDR_CTRL, 16'h0200);
        // the msb is taken before the pin turns round, so it reads the floating inverse
        i_acs_host_model.frame(16'h0ff0, rx); chk(rx, 16'h9337);
        chk(16'(i_acs_host_model.saw_din), 16'h0001);
        chk(16'(i_acs_host_model.saw_dout), 16'h0000);
        chk(16'(din_oe_out), 16'h0000);
        stop_test();
    end
endmodule
bind acs_conv_ctrl acs_conv_chk #(.CAL_FULL_CYC(CAL_FULL_CYC), .CAL_DACFS_CYC(CAL_DACFS_CYC),
    .CAL_OFS_CYC(CAL_OFS_CYC)) i_acs_conv_chk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .conversion_start_n_in(conversion_start_n_in), .sample_data_in(sample_data_in), .polarity_in(polarity_in),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .sync_n_in(sync_n_in),
    .dout_out(dout_out), .dout_oe_out(dout_oe_out), .din_in(din_in), .din_out(din_out), .din_oe_out(din_oe_out),
    .busy_out(busy_out), .result_ready_out(result_ready_out), .partial_pd_out(partial_pd_out),
    .full_pd_out(full_pd_out));
